// >>> hdl/host_serial_port.sv
// host serial command port: 8N1 uart, multidrop addressing, mode straps,
// busy and touch-notification lines, APB register slave, transmit fifo
// assumes pclk at 50 MHz, rxd and straps synchronous to pclk
// How it works
// - link defaults to 115.2 kbaud, 8 data bits, no parity, one stop bit.
// - one port serves point-to-point or multidrop with same rx, tx, enable.
// - station address is software-set, writes outside 1..254 are ignored.
// - station address is 16 until software sets another value.
// - active-high output switches the external bus line driver.
// - straps decode to normal, test, calibration or card programming.
// - test mode forces address 16 and 115.2 kbaud, ignoring stored setup.
// - programming mode raises a request to copy the card into flash.
// - busy is low when ready; host sends commands only while low.
// - busy is held about 500 ms after reset before ready.
// - each processed touch gives an active-low pulse of about 10 ms.

// synchronous fifo with valid/ready on both sides
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic [WIDTH-1:0] in_data, // write data
  input wire logic in_valid, // write request
  output logic in_ready, // not full
  output logic [WIDTH-1:0] out_data, // head word
  output logic out_valid, // not empty
  input wire logic out_ready // pop
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q;
  logic push, pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_ready && out_valid;

  // storage array
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module host_serial_port
  import serial_port_pkg::*;
#(
  parameter int unsigned BOOT_CYCLES = BOOT_CYC,
  parameter int unsigned TOUCH_CYCLES = TOUCH_CYC
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic rxd, // serial receive
  output logic txd, // serial transmit
  output logic line_driver_enable, // bus transmitter enable, high on
  input wire logic mode_sw1, // mode strap 1, high is on
  input wire logic mode_sw2, // mode strap 2, high is on
  output logic [1:0] op_mode, // latched operating mode
  output logic card_copy_req, // program mode: copy card to flash
  output logic busy, // high busy, low ready
  output logic touch_event_pulse_n // active-low touch pulse
);
  logic [1:0] mode_q;
  logic strap_done_q, multidrop_q, sw_busy_q, busy_q, touch_n_q, first_q, sel_q;
  logic [7:0] station_address_q, addr_eff, rx_sh_q, rx_data_q, txf_data;
  logic [15:0] baud_div_q, div_eff, rx_cnt_q, tx_cnt_q;
  logic acc, wr, rd, known, rx_done_q, rx_valid_q, rx_ovr_q;
  logic txd_q, de_q, txf_pop, txf_ready, txf_valid, txf_push;
  logic [31:0] rdata;
  logic [24:0] boot_cnt_q, touch_cnt_q;
  logic [23:0] gap_q;
  logic [2:0] rx_bit_q;
  logic [3:0] tx_bit_q;
  logic [9:0] tx_sh_q;
  rx_state_t rx_st_q;
  tx_state_t tx_st_q;
  // straps caught once after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_NORMAL;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      mode_q <= {mode_sw2, mode_sw1};
      strap_done_q <= 1'b1;
    end
  end
  // test mode overrides stored address and rate
  assign addr_eff = (mode_q == MODE_TEST) ? ADDR_RST : station_address_q;
  assign div_eff = (mode_q == MODE_TEST) ? BAUD_DIV_RST : baud_div_q;
  // apb decode: pready is raised one cycle into the access phase
  assign known = (paddr[7:2] <= OFS_NOTIFY[7:2]) && (paddr[1:0] == 2'h0);
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite && known;
  assign rd = acc && !pwrite && known;
  assign txf_push = wr && (paddr == OFS_TXD);
  // read mux
  always_comb begin
    rdata = 32'h0;
    case (paddr)
      OFS_CTRL: rdata = {30'h0, sw_busy_q, multidrop_q};
      OFS_ADDR: rdata = {24'h0, addr_eff};
      OFS_BAUD: rdata = {16'h0, div_eff};
      OFS_STAT: rdata = {24'h0, sel_q, tx_st_q == TX_SHIFT, !txf_ready,
                         rx_ovr_q, rx_valid_q, busy_q, mode_q};
      OFS_RXD: rdata = {24'h0, rx_data_q};
      default: rdata = 32'h0;
    endcase
  end
  // apb answer; a push to a full transmit fifo waits for room
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready &&
                 !(pwrite && paddr == OFS_TXD && !txf_ready)) begin
      pready <= 1'b1;
      prdata <= rdata;
      pslverr <= !known;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end
  // control, address and rate registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      multidrop_q <= 1'b0;
      sw_busy_q <= 1'b0;
      station_address_q <= ADDR_RST;
      baud_div_q <= BAUD_DIV_RST;
    end else if (wr) begin
      if (paddr == OFS_CTRL) begin
        multidrop_q <= pwdata[CTRL_MULTIDROP];
        sw_busy_q <= pwdata[CTRL_BUSY];
      end
      if (paddr == OFS_ADDR && pwdata[7:0] >= ADDR_MIN &&
          pwdata[7:0] <= ADDR_MAX) begin
        station_address_q <= pwdata[7:0];
      end
      if (paddr == OFS_BAUD && pwdata[15:0] > 16'h0001) begin
        baud_div_q <= pwdata[15:0];
      end
    end
  end
  // busy: boot hold after reset, then software busy bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_cnt_q <= 25'(BOOT_CYCLES);
      busy_q <= 1'b1;
    end else begin
      if (boot_cnt_q != '0) boot_cnt_q <= boot_cnt_q - 1'b1;
      busy_q <= (boot_cnt_q > 25'h1) || sw_busy_q;
    end
  end
  // touch pulse, retriggered by each notify write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      touch_cnt_q <= '0;
      touch_n_q <= 1'b1;
    end else if (wr && paddr == OFS_NOTIFY) begin
      touch_cnt_q <= 25'(TOUCH_CYCLES);
      touch_n_q <= 1'b0;
    end else if (touch_cnt_q > 25'h1) begin
      touch_cnt_q <= touch_cnt_q - 1'b1;
    end else begin
      touch_cnt_q <= '0;
      touch_n_q <= 1'b1;
    end
  end
  // receiver: mid-bit sampling with a half-bit start check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q <= '0;
      rx_done_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      case (rx_st_q)
        RX_IDLE: if (!rxd) begin
          rx_st_q <= RX_START;
          rx_cnt_q <= {1'b0, div_eff[15:1]};
        end
        RX_START: if (rx_cnt_q != '0) rx_cnt_q <= rx_cnt_q - 1'b1;
          else if (!rxd) begin
            rx_st_q <= RX_DATA;
            rx_cnt_q <= div_eff - 1'b1;
            rx_bit_q <= '0;
          end else rx_st_q <= RX_IDLE;
        RX_DATA: if (rx_cnt_q != '0) rx_cnt_q <= rx_cnt_q - 1'b1;
          else begin
            rx_sh_q <= {rxd, rx_sh_q[7:1]};
            rx_cnt_q <= div_eff - 1'b1;
            rx_bit_q <= rx_bit_q + 1'b1;
            if (rx_bit_q == 3'h7) rx_st_q <= RX_STOP;
          end
        RX_STOP: if (rx_cnt_q != '0) rx_cnt_q <= rx_cnt_q - 1'b1;
          else begin
            rx_done_q <= rxd;
            rx_st_q <= RX_IDLE;
          end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end
  // multidrop framing: first byte after an idle gap is the address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= '0;
      first_q <= 1'b1;
      sel_q <= 1'b0;
    end else begin
      if (rx_st_q != RX_IDLE || !rxd) gap_q <= '0;
      else if (gap_q < 24'(div_eff) * 24'(IDLE_GAP_BITS)) gap_q <= gap_q + 1'b1;
      else first_q <= 1'b1;
      if (rx_done_q && multidrop_q && first_q) begin
        sel_q <= (rx_sh_q == addr_eff);
        first_q <= 1'b0;
      end
    end
  end
  // receive holding register, new byte wins over a pop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_q <= '0;
      rx_valid_q <= 1'b0;
      rx_ovr_q <= 1'b0;
    end else begin
      if (rx_done_q && (!multidrop_q || (!first_q && sel_q))) begin
        rx_data_q <= rx_sh_q;
        rx_valid_q <= 1'b1;
        if (rx_valid_q && !(rd && paddr == OFS_RXD)) rx_ovr_q <= 1'b1;
      end else if (rd && paddr == OFS_RXD) begin
        rx_valid_q <= 1'b0;
      end
      if (wr && paddr == OFS_STAT && pwdata[STAT_OVR] &&
          !(rx_done_q && rx_valid_q)) rx_ovr_q <= 1'b0;
    end
  end
  // transmit buffer between the register bus and the shifter
  sync_fifo #(.WIDTH(TXF_WIDTH), .DEPTH(TXF_DEPTH)) u_txf (
    .pclk(pclk),
    .presetn(presetn),
    .in_data(pwdata[7:0]),
    .in_valid(txf_push),
    .in_ready(txf_ready),
    .out_data(txf_data),
    .out_valid(txf_valid),
    .out_ready(txf_pop)
  );

  assign txf_pop = (tx_st_q == TX_IDLE) && txf_valid;

  // transmitter: start bit, 8 data bits lsb first, stop bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q <= TX_IDLE;
      tx_cnt_q <= '0;
      tx_bit_q <= '0;
      tx_sh_q <= 10'h3ff;
      txd_q <= 1'b1;
    end else begin
      case (tx_st_q)
        TX_IDLE: if (txf_valid) begin
          tx_sh_q <= {1'b1, txf_data, 1'b0};
          tx_bit_q <= '0;
          tx_cnt_q <= '0;
          tx_st_q <= TX_SHIFT;
        end
        TX_SHIFT: if (tx_cnt_q != '0) tx_cnt_q <= tx_cnt_q - 1'b1;
          else if (tx_bit_q == 4'ha) tx_st_q <= TX_IDLE;
          else begin
            txd_q <= tx_sh_q[0];
            tx_sh_q <= {1'b1, tx_sh_q[9:1]};
            tx_bit_q <= tx_bit_q + 1'b1;
            tx_cnt_q <= div_eff - 1'b1;
          end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // line driver on only while a reply is going out in multidrop mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) de_q <= 1'b0;
    else de_q <= multidrop_q && (tx_st_q == TX_SHIFT || txf_valid);
  end

  // mode outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_mode <= MODE_NORMAL;
      card_copy_req <= 1'b0;
    end else begin
      op_mode <= mode_q;
      card_copy_req <= strap_done_q && (mode_q == MODE_PROGRAM);
    end
  end

  assign txd = txd_q;
  assign line_driver_enable = de_q;
  assign busy = busy_q;
  assign touch_event_pulse_n = touch_n_q;
endmodule

// >>> hdl/serial_port_pkg.sv
// constants for the host serial command port
// assumes a 50 MHz pclk and an APB master with 32-bit data
package serial_port_pkg;
  // clock and link timing
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned BAUD_DEFAULT = 115200;
  localparam logic [15:0] BAUD_DIV_RST = 16'(CLK_HZ / BAUD_DEFAULT);
  localparam int unsigned IDLE_GAP_BITS = 16;
  localparam int unsigned BOOT_MS = 500;
  localparam int unsigned BOOT_CYC = CLK_HZ / 1000 * BOOT_MS;
  localparam int unsigned TOUCH_MS = 10;
  localparam int unsigned TOUCH_CYC = CLK_HZ / 1000 * TOUCH_MS;
  // station address limits and default
  localparam logic [7:0] ADDR_RST = 8'h10;
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hfe;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_BAUD = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_RXD = 8'h10;
  localparam logic [7:0] OFS_TXD = 8'h14;
  localparam logic [7:0] OFS_NOTIFY = 8'h18;
  // control bits
  localparam int CTRL_MULTIDROP = 0;
  localparam int CTRL_BUSY = 1;
  // status bits
  localparam int STAT_BUSY = 2;
  localparam int STAT_RXV = 3;
  localparam int STAT_OVR = 4;
  localparam int STAT_TXFULL = 5;
  localparam int STAT_TXACT = 6;
  localparam int STAT_SEL = 7;
  // operating modes from the two straps {sw2, sw1}
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_TEST = 2'h1;
  localparam logic [1:0] MODE_CAL = 2'h2;
  localparam logic [1:0] MODE_PROGRAM = 2'h3;
  // transmit buffer shape
  localparam int TXF_WIDTH = 8;
  localparam int TXF_DEPTH = 32;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;
endpackage

// >>> verif/host_serial_port_checker.sv
// checker for the host serial port, bound to its top-level ports
// assumes one pclk domain with presetn active low
module host_serial_port_checker
  import serial_port_pkg::*;
#(
  parameter int unsigned BOOT_CYCLES = 200,
  parameter int unsigned TOUCH_CYCLES = 50
) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic txd, // serial out
  input wire logic line_driver_enable, // bus driver enable
  input wire logic [1:0] op_mode, // latched mode
  input wire logic card_copy_req, // copy request
  input wire logic busy, // busy line
  input wire logic touch_event_pulse_n // touch pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned boot_q;
  int unsigned low_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles since reset release, saturating, and length of the touch pulse so far
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_q <= 0;
      low_q <= 0;
    end else begin
      boot_q <= boot_q + 32'(boot_q < BOOT_CYCLES);
      low_q <= touch_event_pulse_n ? 0 : low_q + 1;
    end
  end
  property p_boot_busy; !busy |-> boot_q + 2 >= BOOT_CYCLES; endproperty
  a_boot_busy: assert property (p_boot_busy) else $error("busy dropped early");
  property p_reset_busy; $rose(presetn) |-> busy [*8]; endproperty
  a_reset_busy: assert property (p_reset_busy) else $error("busy low after reset");
  property p_touch_go;
    psel && penable && pready && pwrite && paddr == OFS_NOTIFY |=> !touch_event_pulse_n;
  endproperty
  a_touch_go: assert property (p_touch_go) else $error("touch pulse missing");
  property p_touch_len; $rose(touch_event_pulse_n) |-> low_q == TOUCH_CYCLES; endproperty
  a_touch_len: assert property (p_touch_len) else $error("touch pulse length");
  property p_mode_hold; !$stable(op_mode) |-> !$past(presetn, 3); endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed in run");
  property p_program; op_mode == MODE_PROGRAM |-> ##[0:2] card_copy_req; endproperty
  a_program: assert property (p_program) else $error("no copy request");
  property p_de_stop; $fell(line_driver_enable) |-> txd; endproperty
  a_de_stop: assert property (p_de_stop) else $error("driver off mid frame");
  property p_de_start; $rose(line_driver_enable) |-> ##[0:3] !txd; endproperty
  a_de_start: assert property (p_de_start) else $error("driver on, no frame");
  property p_start_bit; $fell(txd) |-> !txd [*8]; endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit too short");
  c_touch: cover property ($fell(touch_event_pulse_n));
  c_driver: cover property ($rose(line_driver_enable));
  c_slverr: cover property (pslverr);
  c_program: cover property (card_copy_req);
endmodule

bind host_serial_port host_serial_port_checker #(
  .BOOT_CYCLES(BOOT_CYCLES), .TOUCH_CYCLES(TOUCH_CYCLES)
) host_serial_port_checker_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .txd,
  .line_driver_enable, .op_mode, .card_copy_req, .busy, .touch_event_pulse_n
);

// >>> verif/host_uart_model.sv
// host side of the serial link: sends and hears 8N1 frames
// assumes frames timed in pclk cycles, div set by the bench
module host_uart_model (
  input wire logic pclk, // clock
  input wire logic busy, // device busy
  input wire logic txd, // device serial out
  output logic rxd // device serial in
);
  timeunit 1ns;
  timeprecision 1ns;
  int div = 434;
  logic [7:0] rx_q[$];
  initial rxd = 1'b1;
  // one frame, start bit first, then data lsb first, then stop
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    while (busy !== 1'b0) @(posedge pclk);
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (div) @(posedge pclk);
    end
  endtask
  // receiver samples each bit in its middle
  always begin
    logic [7:0] b;
    @(negedge txd);
    repeat (div / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge pclk);
      b[i] = txd;
    end
    rx_q.push_back(b);
    repeat (div) @(posedge pclk);
  end
endmodule

// >>> verif/testbench.sv
// self-checking bench for the host serial port
// assumes the host model and the bound checker beside the design
module testbench
  import serial_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned BOOT = 200;
  localparam int unsigned TOUCH = 50;
  localparam logic [7:0] READ_UI_MESSAGE_CMD = 8'h5a; // command code, value arbitrary
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic mode_sw1 = 1'b0, mode_sw2 = 1'b0, pready, pslverr, err, rxd, txd, busy;
  logic line_driver_enable, card_copy_req, touch_event_pulse_n;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [1:0] op_mode;
  int bad_count = 0, tests_run = 0;
  integer seed = 32'hba10;
  always #10 pclk = ~pclk;
  host_serial_port #(.BOOT_CYCLES(BOOT), .TOUCH_CYCLES(TOUCH)) host_serial_port_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rxd, .txd, .line_driver_enable, .mode_sw1, .mode_sw2, .op_mode,
    .card_copy_req, .busy, .touch_event_pulse_n
  );
  host_uart_model host_uart_model_i (.pclk, .busy, .txd, .rxd);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 9999);
    if (pready !== 1'b1) bad_count++; // the bus answer never came
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdat, exp);
  endtask
  task automatic wait_rx(input int n);
    int k;
    k = 0;
    while (host_uart_model_i.rx_q.size() < n && k < 60000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 60000) bad_count++; // frames never arrived
  endtask
  task automatic tx_chk(input logic [7:0] exp);
    wait_rx(1);
    check(32'(host_uart_model_i.rx_q.pop_front()), 32'(exp));
  endtask
  // reset with given straps, time the boot hold, then flip the straps
  task automatic start(input logic [1:0] m);
    int n;
    presetn <= 1'b0;
    {mode_sw2, mode_sw1} <= m;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (busy !== 1'b0 && n < 999);
    check(32'(n + 2 >= BOOT && n <= BOOT + 4), 32'h1);
    {mode_sw2, mode_sw1} <= ~m;
    repeat (3) @(posedge pclk);
  endtask
  initial begin
    #(20 * 80000); // tests need about 58000 cycles
    bad_count++;
    stop_test();
  end
  initial begin
    logic [7:0] b;
    logic [7:0] q[$];
    start(MODE_NORMAL);
    rd_chk(OFS_ADDR, 32'h10);
    rd_chk(OFS_BAUD, 32'h1b2);
    wr(OFS_ADDR, 32'h0);
    wr(OFS_ADDR, 32'hff);
    rd_chk(OFS_ADDR, 32'h10);
    for (int i = 0; i < 5; i++) begin
      b = i == 0 ? 8'h01 : i == 1 ? 8'hfe : 8'(({$random(seed)} % 254) + 1);
      wr(OFS_ADDR, 32'(b));
      rd_chk(OFS_ADDR, 32'(b));
    end
    apb(1'b0, 8'h1c, 32'h0);
    check(32'(err), 32'h1);
    $display("test registers done");
    b = 8'($random(seed));
    wr(OFS_TXD, 32'(b));
    repeat (40) @(posedge pclk);
    check(32'(line_driver_enable), 32'h0);
    tx_chk(b);
    b = 8'($random(seed));
    host_uart_model_i.send_byte(b);
    rd_chk(OFS_RXD, 32'(b));
    $display("test point to point done");
    wr(OFS_CTRL, 32'h1);
    wr(OFS_ADDR, 32'h2a);
    for (int i = 0; i < 2; i++) begin
      repeat (16 * 434 + 10) @(posedge pclk);
      host_uart_model_i.send_byte(8'h2a ^ 8'(i));
      host_uart_model_i.send_byte(8'h5c);
      apb(1'b0, OFS_STAT, 32'h0);
      check(32'(rdat[STAT_RXV]), 32'(i == 0));
      if (i == 0)
        rd_chk(OFS_RXD, 32'h5c);
    end
    wr(OFS_TXD, 32'h3c);
    repeat (40) @(posedge pclk);
    check(32'(line_driver_enable), 32'h1);
    tx_chk(8'h3c);
    repeat (900) @(posedge pclk);
    check(32'(line_driver_enable), 32'h0);
    $display("test multidrop done");
    wr(OFS_BAUD, 32'h20);
    host_uart_model_i.div = 32;
    for (int i = 0; i < 34; i++) begin
      q.push_back(8'($random(seed)));
      wr(OFS_TXD, 32'(q[i]));
      if (i == 32) begin
        apb(1'b0, OFS_STAT, 32'h0);
        check(32'(rdat[STAT_TXFULL]), 32'h1);
      end
    end
    wait_rx(34);
    foreach (q[i]) check(32'(host_uart_model_i.rx_q[i]), 32'(q[i]));
    $display("test buffer done");
    wr(OFS_NOTIFY, 32'h1);
    check(32'(touch_event_pulse_n), 32'h0);
    repeat (TOUCH + 2) @(posedge pclk);
    check(32'(touch_event_pulse_n), 32'h1);
    wr(OFS_CTRL, 32'h2);
    repeat (2) @(posedge pclk);
    check(32'(busy), 32'h1);
    wr(OFS_CTRL, 32'h0);
    repeat (2) @(posedge pclk);
    check(32'(busy), 32'h0);
    // host answers the touch pulse with the message read command
    host_uart_model_i.send_byte(READ_UI_MESSAGE_CMD);
    rd_chk(OFS_RXD, 32'(READ_UI_MESSAGE_CMD));
    // two bytes without a read: overrun set, newest byte kept, then cleared
    for (int i = 0; i < 2; i++) host_uart_model_i.send_byte(8'(i));
    apb(1'b0, OFS_STAT, 32'h0);
    check(32'(rdat[STAT_OVR]), 32'h1);
    rd_chk(OFS_RXD, 32'h1);
    wr(OFS_STAT, 32'h1 << STAT_OVR);
    apb(1'b0, OFS_STAT, 32'h0);
    check(32'(rdat[STAT_OVR]), 32'h0);
    $display("test handshake done");
    for (int m = 0; m < 4; m++) begin
      start(2'(m));
      check(32'(op_mode), 32'(m));
      check(32'(card_copy_req), 32'(m == 3));
      wr(OFS_ADDR, 32'h33);
      rd_chk(OFS_ADDR, m == 1 ? 32'h10 : 32'h33);
      wr(OFS_BAUD, 32'h20);
      rd_chk(OFS_BAUD, m == 1 ? 32'h1b2 : 32'h20);
    end
    $display("test modes done");
    stop_test();
  end
endmodule
